// [hw/cfg_fuse_pkg.sv]
// Summary of operation
// - Watchdog postscale ratio is two to the power of fuse bits 3..1.
// - Watchdog hard enable bit forces the watchdog on; otherwise software enable decides.
// - Capture unit 2 route bit picks port C bit 1 when set, port B bit 3 when clear.
// - Debugger disable bit high keeps port B bits 6 and 7 general purpose.
// - Debug byte bit 2 enables low-voltage serial programming when high.
// - Stack fault reset enable makes stack full or underflow reset the device.
// - Four block code protect bits guard program blocks 0 to 3 when low.
// - Data EEPROM code protect bit 7 protects the EEPROM when low.
// - Boot code protect bit 6 protects 000000-0001FFh when low.
// - Four block write protect bits block program writes to their block when low.
// - EEPROM write protect bit 7 inhibits data EEPROM writes when low.
// - Boot write protect bit 6 inhibits writes to 000000-0001FFh when low.
// - Config write protect bit 5 locks 300000-3000FFh when low; fixed in user mode.
// - Block table-read protect bits block reads from code in other blocks when low.
// - Boot table-read protect bit blocks boot reads from other blocks when low.
// - Unimplemented bit positions of every configuration byte read as zero.
// - A programmed bit reads as zero, an unprogrammed bit as one.
// - Configuration bytes are reached only by table reads and table writes.
package cfg_fuse_pkg;
   localparam int unsigned ADDR_W = 22;
   // Configuration space bounds
   localparam logic [21:0] CFG_BASE = 22'h30_0000;
   localparam logic [21:0] CFG_WR_LAST = 22'h30_00FF;
   localparam logic [21:0] CFG_SPACE_LAST = 22'h3F_FFFF;
   // Byte addresses of the bank
   localparam logic [21:0] WDT_CFG_ADDR = 22'h30_0003;
   localparam logic [21:0] ROUTE_CFG_ADDR = 22'h30_0005;
   localparam logic [21:0] DBG_CFG_ADDR = 22'h30_0006;
   localparam logic [21:0] CP_LO_ADDR = 22'h30_0008;
   localparam logic [21:0] CP_HI_ADDR = 22'h30_0009;
   localparam logic [21:0] WP_LO_ADDR = 22'h30_000A;
   localparam logic [21:0] WP_HI_ADDR = 22'h30_000B;
   localparam logic [21:0] TR_LO_ADDR = 22'h30_000C;
   localparam logic [21:0] TR_HI_ADDR = 22'h30_000D;
   // Implemented bits of each byte
   localparam logic [7:0] WDT_IMPL = 8'h0F;
   localparam logic [7:0] ROUTE_IMPL = 8'h01;
   localparam logic [7:0] DBG_IMPL = 8'h85;
   localparam logic [7:0] LO4_IMPL = 8'h0F;
   localparam logic [7:0] CP_HI_IMPL = 8'hC0;
   localparam logic [7:0] WP_HI_IMPL = 8'hE0;
   localparam logic [7:0] TR_HI_IMPL = 8'h40;
   // Unprogrammed values
   localparam logic [7:0] WDT_RST = 8'h0F;
   localparam logic [7:0] ROUTE_RST = 8'h01;
   localparam logic [7:0] DBG_RST = 8'h85;
   localparam logic [7:0] LO4_RST = 8'h0F;
   localparam logic [7:0] CP_HI_RST = 8'hC0;
   localparam logic [7:0] WP_HI_RST = 8'hE0;
   localparam logic [7:0] TR_HI_RST = 8'h40;
   // Bits that user code may only clear
   localparam logic [7:0] LO4_CLR = 8'h0F;
   localparam logic [7:0] CP_HI_CLR = 8'hC0;
   localparam logic [7:0] WP_HI_CLR = 8'hC0;
   localparam logic [7:0] TR_HI_CLR = 8'h40;
   // Field positions
   localparam int unsigned WD_EN_BIT = 0;
   localparam int unsigned WD_PS_LSB = 1;
   localparam int unsigned WD_PS_W = 3;
   localparam int unsigned ROUTE_BIT = 0;
   localparam int unsigned DBG_DIS_BIT = 7;
   localparam int unsigned LVP_BIT = 2;
   localparam int unsigned STK_BIT = 0;
   localparam int unsigned EE_BIT = 7;
   localparam int unsigned BOOT_BIT = 6;
   localparam int unsigned CFGWP_BIT = 5;
   localparam int unsigned NUM_BLOCKS = 4;
   // Unlock keys
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
   // Self-timed write duration
   localparam int unsigned WRITE_TIME_US = 2000;
   localparam int unsigned CLK_FREQ_MHZ = 25;
   localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_FREQ_MHZ;
   // Program memory region ends
   localparam logic [21:0] BOOT_END = 22'h00_01FF;
   localparam logic [21:0] BLK0_END = 22'h00_1FFF;
   localparam logic [21:0] BLK1_END = 22'h00_3FFF;
   localparam logic [21:0] BLK2_END = 22'h00_5FFF;
   localparam logic [21:0] BLK3_END = 22'h00_7FFF;

   typedef enum logic [2:0] {RGN_BOOT, RGN_BLK0, RGN_BLK1, RGN_BLK2, RGN_BLK3, RGN_NONE} region_t;
   typedef enum logic [1:0] {WS_IDLE = 2'b00, WS_KEY1 = 2'b01, WS_ARMED = 2'b11, WS_BUSY = 2'b10} wr_state_t;

   // Implemented mask by low address nibble; unmapped nibbles hold nothing
   function automatic logic [7:0] impl_mask(input logic [3:0] idx);
      unique case (idx)
         WDT_CFG_ADDR[3:0]: impl_mask = WDT_IMPL;
         ROUTE_CFG_ADDR[3:0]: impl_mask = ROUTE_IMPL;
         DBG_CFG_ADDR[3:0]: impl_mask = DBG_IMPL;
         CP_LO_ADDR[3:0], WP_LO_ADDR[3:0], TR_LO_ADDR[3:0]: impl_mask = LO4_IMPL;
         CP_HI_ADDR[3:0]: impl_mask = CP_HI_IMPL;
         WP_HI_ADDR[3:0]: impl_mask = WP_HI_IMPL;
         TR_HI_ADDR[3:0]: impl_mask = TR_HI_IMPL;
         default: impl_mask = 8'h00;
      endcase
   endfunction : impl_mask

   function automatic logic [7:0] rst_value(input logic [3:0] idx);
      unique case (idx)
         WDT_CFG_ADDR[3:0]: rst_value = WDT_RST;
         ROUTE_CFG_ADDR[3:0]: rst_value = ROUTE_RST;
         DBG_CFG_ADDR[3:0]: rst_value = DBG_RST;
         CP_LO_ADDR[3:0], WP_LO_ADDR[3:0], TR_LO_ADDR[3:0]: rst_value = LO4_RST;
         CP_HI_ADDR[3:0]: rst_value = CP_HI_RST;
         WP_HI_ADDR[3:0]: rst_value = WP_HI_RST;
         TR_HI_ADDR[3:0]: rst_value = TR_HI_RST;
         default: rst_value = 8'h00;
      endcase
   endfunction : rst_value

   function automatic logic [7:0] clear_mask(input logic [3:0] idx);
      unique case (idx)
         CP_LO_ADDR[3:0], WP_LO_ADDR[3:0], TR_LO_ADDR[3:0]: clear_mask = LO4_CLR;
         CP_HI_ADDR[3:0]: clear_mask = CP_HI_CLR;
         WP_HI_ADDR[3:0]: clear_mask = WP_HI_CLR;
         TR_HI_ADDR[3:0]: clear_mask = TR_HI_CLR;
         default: clear_mask = 8'h00;
      endcase
   endfunction : clear_mask
endpackage : cfg_fuse_pkg

// [hw/region_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Address in, program memory region out
interface region_if import cfg_fuse_pkg::*; ();
   logic [ADDR_W-1:0] addr;
   region_t region;
   modport guard (input addr, output region);
   modport user (output addr, input region);
endinterface : region_if
`default_nettype wire

// [hw/region_guard.sv]
`timescale 1ns/1ps
`default_nettype none
module region_guard (
   // Address and decoded region
   region_if.guard rgn
);
   import cfg_fuse_pkg::*;

   // Ranges are contiguous, so ordered compares pick the region
   always_comb begin
      if (rgn.addr <= BOOT_END) begin
         rgn.region = RGN_BOOT;
      end else if (rgn.addr <= BLK0_END) begin
         rgn.region = RGN_BLK0;
      end else if (rgn.addr <= BLK1_END) begin
         rgn.region = RGN_BLK1;
      end else if (rgn.addr <= BLK2_END) begin
         rgn.region = RGN_BLK2;
      end else if (rgn.addr <= BLK3_END) begin
         rgn.region = RGN_BLK3;
      end else begin
         rgn.region = RGN_NONE;
      end
   end
endmodule : region_guard
`default_nettype wire

// [hw/cfg_fuse_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module cfg_fuse_bank #(
   parameter int unsigned WRITE_CYCLES_P = cfg_fuse_pkg::WRITE_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Table access port
   input wire logic [cfg_fuse_pkg::ADDR_W-1:0] tbl_addr_i,
   input wire logic tbl_rd_i,
   input wire logic tbl_wr_i,
   input wire logic [7:0] tbl_wr_data_i,
   output logic tbl_rd_valid_o,
   output logic [7:0] tbl_rd_data_o,
   // Write sequencing controls
   input wire logic cfg_select_i,
   input wire logic write_enable_i,
   input wire logic unlock_wr_i,
   input wire logic [7:0] unlock_data_i,
   input wire logic write_start_i,
   input wire logic user_mode_i,
   output logic write_busy_o,
   output logic write_done_o,
   output logic write_err_o,
   // Protection checks
   input wire logic [cfg_fuse_pkg::ADDR_W-1:0] exec_addr_i,
   input wire logic [cfg_fuse_pkg::ADDR_W-1:0] prog_wr_addr_i,
   output logic tbl_rd_blocked_o,
   output logic prog_wr_blocked_o,
   output logic eeprom_wr_blocked_o,
   output logic eeprom_code_protect_o,
   output logic boot_code_protect_o,
   output logic [cfg_fuse_pkg::NUM_BLOCKS-1:0] block_code_protect_o,
   // Watchdog options
   input wire logic wd_soft_enable_i,
   output logic [2:0] wd_postscale_sel_o,
   output logic [7:0] wd_postscale_ratio_o,
   output logic wd_enable_o,
   // Capture unit 2 pin routing
   input wire logic cu2_out_i,
   input wire logic cu2_oe_i,
   output logic cu2_in_o,
   input wire logic pc1_gp_out_i,
   input wire logic pc1_gp_oe_i,
   input wire logic port_c_bit1_in_i,
   output logic port_c_bit1_out_o,
   output logic port_c_bit1_oe_o,
   input wire logic pb3_gp_out_i,
   input wire logic pb3_gp_oe_i,
   input wire logic port_b_bit3_in_i,
   output logic port_b_bit3_out_o,
   output logic port_b_bit3_oe_o,
   // Debug, programming and stack options
   output logic debug_enable_o,
   output logic port_b_bit67_gpio_o,
   output logic low_volt_prog_enable_o,
   input wire logic stack_full_i,
   input wire logic stack_underflow_i,
   output logic stack_reset_o
);
   import cfg_fuse_pkg::*;

   localparam int unsigned CNT_W = $clog2(WRITE_CYCLES_P + 1);
   localparam logic [3:0] WDT_IDX = WDT_CFG_ADDR[3:0];
   localparam logic [3:0] ROUTE_IDX = ROUTE_CFG_ADDR[3:0];
   localparam logic [3:0] DBG_IDX = DBG_CFG_ADDR[3:0];
   localparam logic [3:0] CPL_IDX = CP_LO_ADDR[3:0];
   localparam logic [3:0] CPH_IDX = CP_HI_ADDR[3:0];
   localparam logic [3:0] WPL_IDX = WP_LO_ADDR[3:0];
   localparam logic [3:0] WPH_IDX = WP_HI_ADDR[3:0];
   localparam logic [3:0] TRL_IDX = TR_LO_ADDR[3:0];
   localparam logic [3:0] TRH_IDX = TR_HI_ADDR[3:0];

   logic [7:0] cfg_r [16];
   logic [ADDR_W-1:0] hold_addr_r;
   logic [7:0] hold_data_r;
   wr_state_t state_r;
   logic [CNT_W-1:0] busy_cnt_r;
   logic done_r;
   logic err_r;
   logic rd_valid_r;
   logic [7:0] rd_data_r;
   logic stack_rst_r;
   logic [3:0] hold_idx;
   logic wr_in_range;
   logic wr_allowed;
   logic start_req;
   logic commit;
   logic rd_is_cfg;
   logic [3:0] wp_lo;
   logic [3:0] tr_lo;
   logic route_pc1;

   region_if tgt_if ();
   region_if exe_if ();
   region_if pwr_if ();

   // One decoder per address that needs a region
   region_guard u_tgt_guard (.rgn(tgt_if.guard));
   region_guard u_exe_guard (.rgn(exe_if.guard));
   region_guard u_pwr_guard (.rgn(pwr_if.guard));

   assign tgt_if.addr = tbl_addr_i;
   assign exe_if.addr = exec_addr_i;
   assign pwr_if.addr = prog_wr_addr_i;

   // User code may only clear protection bits, never set them back
   function automatic logic [7:0] apply_write(input logic [3:0] idx, input logic [7:0] old,
                                             input logic [7:0] d, input logic user);
      logic [7:0] clr;
      logic [7:0] v;
      clr = clear_mask(idx);
      v = d;
      if (user) begin
         v = (d & ~clr) | (d & old & clr);
         if (idx == WPH_IDX) begin
            v[CFGWP_BIT] = old[CFGWP_BIT];
         end
      end
      return v & impl_mask(idx);
   endfunction : apply_write

   // Write target checks
   assign hold_idx = hold_addr_r[3:0];
   assign wr_in_range = (hold_addr_r >= CFG_BASE) && (hold_addr_r <= CFG_WR_LAST);
   assign wr_allowed = wr_in_range && (impl_mask(hold_idx) != 8'h00) && cfg_r[WPH_IDX][CFGWP_BIT];
   assign start_req = (state_r == WS_ARMED) && write_start_i && cfg_select_i && write_enable_i;
   assign commit = (state_r == WS_BUSY) && (busy_cnt_r == CNT_W'(1));

   // Holding latch of the table write; frozen while a write is timing
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_addr_r <= '0;
         hold_data_r <= 8'h00;
      end else if (tbl_wr_i && (state_r != WS_BUSY)) begin
         hold_addr_r <= tbl_addr_i;
         hold_data_r <= tbl_wr_data_i;
      end
   end

   // Unlock and timed write sequence; a wrong key drops back to idle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= WS_IDLE;
      end else begin
         unique case (state_r)
            WS_IDLE: begin
               if (unlock_wr_i && (unlock_data_i == UNLOCK_KEY1)) begin
                  state_r <= WS_KEY1;
               end
            end
            WS_KEY1: begin
               if (unlock_wr_i) begin
                  state_r <= (unlock_data_i == UNLOCK_KEY2) ? WS_ARMED : WS_IDLE;
               end
            end
            WS_ARMED: begin
               if (start_req) begin
                  state_r <= wr_allowed ? WS_BUSY : WS_IDLE;
               end else if (write_start_i || unlock_wr_i) begin
                  state_r <= WS_IDLE;
               end
            end
            WS_BUSY: begin
               if (commit) begin
                  state_r <= WS_IDLE;
               end
            end
         endcase
      end
   end

   // Write duration counter
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_cnt_r <= '0;
      end else if (start_req && wr_allowed) begin
         busy_cnt_r <= CNT_W'(WRITE_CYCLES_P);
      end else if (state_r == WS_BUSY) begin
         busy_cnt_r <= busy_cnt_r - CNT_W'(1);
      end
   end

   // Byte store; reset brings back the unprogrammed pattern
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 16; i++) begin
            cfg_r[i] <= rst_value(4'(i));
         end
      end else if (commit) begin
         cfg_r[hold_idx] <= apply_write(hold_idx, cfg_r[hold_idx], hold_data_r, user_mode_i);
      end
   end

   // Write status pulses
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         done_r <= commit;
         err_r <= start_req && !wr_allowed;
      end
   end

   // Table read of the configuration space only
   assign rd_is_cfg = (tbl_addr_i >= CFG_BASE) && (tbl_addr_i <= CFG_SPACE_LAST);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_valid_r <= 1'b0;
         rd_data_r <= 8'h00;
      end else begin
         rd_valid_r <= tbl_rd_i && rd_is_cfg;
         if (tbl_rd_i && rd_is_cfg) begin
            if (tbl_addr_i[ADDR_W-1:4] == CFG_BASE[ADDR_W-1:4]) begin
               rd_data_r <= cfg_r[tbl_addr_i[3:0]] & impl_mask(tbl_addr_i[3:0]);
            end else begin
               rd_data_r <= 8'h00;
            end
         end
      end
   end

   // Stack fault reset request, one cycle behind the condition
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stack_rst_r <= 1'b0;
      end else begin
         stack_rst_r <= cfg_r[DBG_IDX][STK_BIT] && (stack_full_i || stack_underflow_i);
      end
   end

   // Outputs follow the stored bits with no sampling stage
   assign wp_lo = cfg_r[WPL_IDX][NUM_BLOCKS-1:0];
   assign tr_lo = cfg_r[TRL_IDX][NUM_BLOCKS-1:0];
   assign wd_postscale_sel_o = cfg_r[WDT_IDX][WD_PS_LSB +: WD_PS_W];
   assign wd_postscale_ratio_o = 8'h01 << wd_postscale_sel_o;
   assign wd_enable_o = cfg_r[WDT_IDX][WD_EN_BIT] || wd_soft_enable_i;
   assign debug_enable_o = !cfg_r[DBG_IDX][DBG_DIS_BIT];
   assign port_b_bit67_gpio_o = cfg_r[DBG_IDX][DBG_DIS_BIT];
   assign low_volt_prog_enable_o = cfg_r[DBG_IDX][LVP_BIT];
   assign block_code_protect_o = ~cfg_r[CPL_IDX][NUM_BLOCKS-1:0];
   assign eeprom_code_protect_o = !cfg_r[CPH_IDX][EE_BIT];
   assign boot_code_protect_o = !cfg_r[CPH_IDX][BOOT_BIT];
   assign eeprom_wr_blocked_o = !cfg_r[WPH_IDX][EE_BIT];

   // Pin route mux; the unused pin falls back to its port driver
   assign route_pc1 = cfg_r[ROUTE_IDX][ROUTE_BIT];
   assign cu2_in_o = route_pc1 ? port_c_bit1_in_i : port_b_bit3_in_i;
   assign port_c_bit1_out_o = route_pc1 ? cu2_out_i : pc1_gp_out_i;
   assign port_c_bit1_oe_o = route_pc1 ? cu2_oe_i : pc1_gp_oe_i;
   assign port_b_bit3_out_o = route_pc1 ? pb3_gp_out_i : cu2_out_i;
   assign port_b_bit3_oe_o = route_pc1 ? pb3_gp_oe_i : cu2_oe_i;

   // Program write guard by target region
   always_comb begin
      unique case (pwr_if.region)
         RGN_BOOT: prog_wr_blocked_o = !cfg_r[WPH_IDX][BOOT_BIT];
         RGN_BLK0: prog_wr_blocked_o = !wp_lo[0];
         RGN_BLK1: prog_wr_blocked_o = !wp_lo[1];
         RGN_BLK2: prog_wr_blocked_o = !wp_lo[2];
         RGN_BLK3: prog_wr_blocked_o = !wp_lo[3];
         default: prog_wr_blocked_o = 1'b0;
      endcase
   end

   // Table read guard; code inside the same block may always read itself
   always_comb begin
      tbl_rd_blocked_o = 1'b0;
      if (tbl_rd_i && (tgt_if.region != exe_if.region)) begin
         unique case (tgt_if.region)
            RGN_BOOT: tbl_rd_blocked_o = !cfg_r[TRH_IDX][BOOT_BIT];
            RGN_BLK0: tbl_rd_blocked_o = !tr_lo[0];
            RGN_BLK1: tbl_rd_blocked_o = !tr_lo[1];
            RGN_BLK2: tbl_rd_blocked_o = !tr_lo[2];
            RGN_BLK3: tbl_rd_blocked_o = !tr_lo[3];
            default: tbl_rd_blocked_o = 1'b0;
         endcase
      end
   end

   assign tbl_rd_valid_o = rd_valid_r;
   assign tbl_rd_data_o = rd_data_r;
   assign write_busy_o = (state_r == WS_BUSY);
   assign write_done_o = done_r;
   assign write_err_o = err_r;
   assign stack_reset_o = stack_rst_r;

   // Helper: length of the last busy stretch
   logic [CNT_W:0] busy_len_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_len_r <= '0;
      end else if (start_req && wr_allowed) begin
         busy_len_r <= '0;
      end else if (write_busy_o) begin
         busy_len_r <= busy_len_r + (CNT_W+1)'(1);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_wdt_ratio: assert property ((tbl_rd_i && tbl_addr_i == WDT_CFG_ADDR) |=>
      $onehot(wd_postscale_ratio_o) && wd_postscale_ratio_o[tbl_rd_data_o[3:1]])
      else $error("postscale ratio does not match stored code");
   chk_wdt_enable: assert property ((tbl_rd_i && tbl_addr_i == WDT_CFG_ADDR) |=>
      (tbl_rd_data_o[0] ? wd_enable_o : (wd_enable_o == wd_soft_enable_i)))
      else $error("watchdog enable wrong");
   chk_route_pin: assert property ((tbl_rd_i && tbl_addr_i == ROUTE_CFG_ADDR) |=>
      (cu2_in_o == (tbl_rd_data_o[0] ? port_c_bit1_in_i : port_b_bit3_in_i)))
      else $error("capture unit 2 routed to wrong pin");
   chk_debug_pins: assert property ((tbl_rd_i && tbl_addr_i == DBG_CFG_ADDR) |=>
      (debug_enable_o == !tbl_rd_data_o[7]) && (low_volt_prog_enable_o == tbl_rd_data_o[2]))
      else $error("debug or low voltage option wrong");
   chk_stack_reset: assert property ((stack_full_i || stack_underflow_i) |=>
      (stack_reset_o == $past(cfg_r[DBG_IDX][STK_BIT])))
      else $error("stack fault reset wrong");
   chk_unimpl_zero: assert property (tbl_rd_valid_o |->
      ((tbl_rd_data_o & ~impl_mask($past(tbl_addr_i[3:0]))) == 8'h00))
      else $error("unimplemented bit read as one");
   chk_cfg_lock: assert property ((start_req && !cfg_r[WPH_IDX][CFGWP_BIT]) |=>
      write_err_o && !write_busy_o)
      else $error("locked configuration write not refused");
   chk_user_lock: assert property ((commit && user_mode_i && hold_idx == WPH_IDX) |=>
      (cfg_r[WPH_IDX][CFGWP_BIT] == $past(cfg_r[WPH_IDX][CFGWP_BIT])))
      else $error("config lock bit changed in user mode");
   chk_write_len: assert property (write_done_o |->
      (busy_len_r == (CNT_W+1)'(WRITE_CYCLES_P)) && !write_busy_o)
      else $error("write duration wrong");
   chk_tblrd_self: assert property (tbl_rd_blocked_o |->
      (tgt_if.region != exe_if.region) && (tgt_if.region != RGN_NONE))
      else $error("table read blocked within own block");
   chk_wr_guard: assert property ((pwr_if.region == RGN_BOOT) |->
      (prog_wr_blocked_o == !cfg_r[WPH_IDX][BOOT_BIT]))
      else $error("boot write guard wrong");
   // Blocks are 8 KiB aligned, so address bits 14:13 name the block independently of the compares
   chk_region_map: assert property (((prog_wr_addr_i > BOOT_END) && (prog_wr_addr_i <= BLK3_END)) |->
      (pwr_if.region == region_t'(3'(prog_wr_addr_i[14:13]) + 3'h1)))
      else $error("program write region decode wrong");

   cov_write_done: cover property (write_done_o);
   cov_write_refused: cover property (write_err_o);
   cov_tblrd_blocked: cover property (tbl_rd_blocked_o);
   cov_stack_reset: cover property (stack_reset_o);
endmodule : cfg_fuse_bank
`default_nettype wire

// [test/config_fuse_protection_bank_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module config_fuse_protection_bank_bench;
   import cfg_fuse_pkg::*;
   logic clk_i = 0, rst_n_i = 0, rd = 0, wr = 0, uw = 0, st = 0, um = 0, sf = 0, su = 0, sw = 0, sel = 1;
   logic [21:0] a = CFG_BASE, ea = 22'h00_0000, pa = 22'h00_0000;
   logic [7:0] wd = 8'h00, ud = 8'h00, r = 8'h00, rdata, ratio;
   logic rv, busy, done, err, wden, dbg, gpio, low_volt_prog_enable, srst, c_o, b_o, cu_in, tb, pb, eb, ecp, bp, c_oe, b_oe;
   logic [2:0] ps;
   logic [3:0] bcp;
   logic [7:0] m [16], im [16];
   int fails = 0, n_tests = 0, seed = 42;
   // Short write time keeps each write near a dozen cycles
   cfg_fuse_bank #(.WRITE_CYCLES_P(8)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .tbl_addr_i(a), .tbl_rd_i(rd),
      .tbl_wr_i(wr), .tbl_wr_data_i(wd), .tbl_rd_valid_o(rv), .tbl_rd_data_o(rdata), .cfg_select_i(sel),
      .write_enable_i(sel), .unlock_wr_i(uw), .unlock_data_i(ud), .write_start_i(st), .user_mode_i(um),
      .write_busy_o(busy), .write_done_o(done), .write_err_o(err), .exec_addr_i(ea), .prog_wr_addr_i(pa),
      .tbl_rd_blocked_o(tb), .prog_wr_blocked_o(pb), .eeprom_wr_blocked_o(eb), .eeprom_code_protect_o(ecp),
      .boot_code_protect_o(bp), .block_code_protect_o(bcp), .wd_soft_enable_i(sw), .wd_postscale_sel_o(ps),
      .wd_postscale_ratio_o(ratio), .wd_enable_o(wden), .cu2_out_i(r[0]), .cu2_oe_i(r[1]), .cu2_in_o(cu_in),
      .pc1_gp_out_i(r[2]), .pc1_gp_oe_i(r[3]), .port_c_bit1_in_i(r[4]), .port_c_bit1_out_o(c_o),
      .port_c_bit1_oe_o(c_oe), .pb3_gp_out_i(r[5]), .pb3_gp_oe_i(r[6]), .port_b_bit3_in_i(r[7]),
      .port_b_bit3_out_o(b_o), .port_b_bit3_oe_o(b_oe), .debug_enable_o(dbg), .port_b_bit67_gpio_o(gpio),
      .low_volt_prog_enable_o(low_volt_prog_enable), .stack_full_i(sf), .stack_underflow_i(su), .stack_reset_o(srst));
   // Clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One table read; valid and data land one cycle after the request
   task automatic rd_chk(input logic [3:0] i);
      @(negedge clk_i);
      a = CFG_BASE | {18'h0_0000, i};
      rd = 1;
      @(negedge clk_i);
      rd = 0;
      chk(rv, 1);
      chk(rdata, m[i]);
   endtask : rd_chk
   // Latch, unlock with both keys, start; e means a refused start
   task automatic wr_byte(input logic [3:0] i, input logic [7:0] d, input logic e);
      @(negedge clk_i);
      a = CFG_BASE | {18'h0_0000, i};
      wd = d;
      wr = 1;
      @(negedge clk_i);
      wr = 0;
      uw = 1;
      ud = UNLOCK_KEY1;
      @(negedge clk_i);
      ud = UNLOCK_KEY2;
      @(negedge clk_i);
      uw = 0;
      st = 1;
      @(negedge clk_i);
      st = 0;
      chk(err, e);
      chk(busy, !e);
      if (!e) begin
         repeat (7) @(negedge clk_i);
         chk(busy, 1);
         @(negedge clk_i);
         chk(done, 1);
         // User code may only clear protection bits and never moves the lock bit
         m[i] = um ? m[i] & (d | 8'h20) : d & im[i];
      end
   endtask : wr_byte
   // Option outputs must follow the stored bytes at all times
   task automatic opts;
      chk(ps, m[3][3:1]);
      chk(ratio, 8'h01 << m[3][3:1]);
      chk(wden, m[3][0] | sw);
      chk(dbg, !m[6][7]);
      chk(gpio, m[6][7]);
      chk(low_volt_prog_enable, m[6][2]);
      chk(bcp, {4'h0, ~m[8][3:0]});
      chk(c_o, m[5][0] ? r[0] : r[2]);
      chk(b_o, m[5][0] ? r[5] : r[0]);
      chk(cu_in, m[5][0] ? r[4] : r[7]);
      chk(c_oe, m[5][0] ? r[1] : r[3]);
      chk(b_oe, m[5][0] ? r[6] : r[1]);
      chk(ecp, !m[9][7]);
      chk(bp, !m[9][6]);
      chk(eb, !m[11][7]);
   endtask : opts
   // Region index from the block map: 0 to 3 blocks, 4 boot, 5 outside program memory
   function automatic int rg(input logic [21:0] x);
      return x <= BOOT_END ? 4 : (x <= BLK3_END ? int'(x[14:13]) : 5);
   endfunction : rg
   // Protection bit of a region read from the model; nothing guards addresses outside
   function automatic logic unprot(input int k, input logic [7:0] lo, input logic [7:0] hi);
      return k < 4 ? lo[k[1:0]] : (k == 4 ? hi[6] : 1'b1);
   endfunction : unprot
   // Random pointer, executing and program-write addresses; the guards answer within the cycle
   task automatic guards;
      @(negedge clk_i);
      a = 22'($random(seed)) & 22'h00_E3FF;
      ea = 22'($random(seed)) & 22'h00_E3FF;
      pa = 22'($random(seed)) & 22'h00_E3FF;
      rd = 1;
      #5;
      chk(tb, (rg(a) != rg(ea)) && !unprot(rg(a), m[12], m[13]));
      chk(pb, !unprot(rg(pa), m[10], m[11]));
      @(negedge clk_i);
      rd = 0;
   endtask : guards
   // Watchdog, far beyond the expected run of about 640 cycles
   initial begin
      #400_000;
      fails++;
      conclude();
   end
   initial begin
      im = '{3: WDT_IMPL, 5: ROUTE_IMPL, 6: DBG_IMPL, 8: LO4_IMPL, 9: CP_HI_IMPL, 10: LO4_IMPL,
             11: WP_HI_IMPL, 12: LO4_IMPL, 13: TR_HI_IMPL, default: 8'h00};
      m = im;
      repeat (6) @(negedge clk_i);
      rst_n_i = 1;
      for (int i = 0; i < 16; i++) rd_chk(4'(i));
      opts();
      // Every postscale code, random routing, debug and stack options
      for (int n = 0; n < 8; n++) begin
         sw = 1'($random(seed));
         r = 8'($random(seed));
         wr_byte(4'h3, 8'($random(seed)) & 8'hF1 | 8'(n << 1), 0);
         wr_byte(4'h5, 8'($random(seed)), 0);
         wr_byte(4'h6, 8'($random(seed)), 0);
         opts();
         sf = n[0];
         su = !n[0];
         @(negedge clk_i);
         chk(srst, m[6][0]);
         sf = 0;
         su = 0;
         rd_chk(4'h3);
         rd_chk(4'h6);
      end
      // Random protection bytes with the lock bit kept set, then random guard queries
      wr_byte(4'h9, 8'($random(seed)), 0);
      wr_byte(4'hA, 8'($random(seed)) | 8'h0C, 0);
      wr_byte(4'hB, 8'($random(seed)) | 8'h20, 0);
      wr_byte(4'hC, 8'($random(seed)), 0);
      wr_byte(4'hD, 8'($random(seed)), 0);
      opts();
      repeat (64) guards();
      // User mode: protection bits clear only, lock bit stays
      um = 1;
      wr_byte(4'h8, 8'($random(seed)), 0);
      wr_byte(4'hB, 8'h40, 0);
      for (int i = 8; i < 12; i++) rd_chk(4'(i));
      opts();
      // Lock cleared outside user mode, after which config writes are refused
      um = 0;
      wr_byte(4'hB, 8'h00, 0);
      wr_byte(4'h3, 8'h00, 1);
      rd_chk(4'h3);
      opts();
      conclude();
   end
endmodule : config_fuse_protection_bank_bench
`default_nettype wire
